// >>> core/scd_regs.svh
// Purpose: Register map, field positions, reset values and wake source count
//          of the system clock divider and power mode controller.
// Assumes: Byte-wide registers on a plain strobe port, 8-bit addresses.
// Notes:   Included by bare name; definitions only.
//
// Contract
// R1 - Divider value zero passes the oscillator clock through undivided.
// R2 - Divider value N from 1 to 255 gives oscillator frequency over 2N.
// R3 - A new divider value is accepted at any time without stalling the CPU.
// R4 - Ratio changes take effect only at a period boundary, no short phases.
// R5 - The clock output pin carries the divided system clock.
// R6 - Clock output enable 0 keeps the pin off, 1 drives the clock out.
// R7 - The clock output pin stops toggling during power-down.
// R8 - Software should leave clock output off where noise or power matters.
// R9 - Writing 1 to the idle bit enters idle after that write.
// R10 - Idle stops the CPU clock only; peripheral clocks keep running.
// R11 - Any enabled interrupt ends idle and hardware clears the idle bit.
// R12 - Any non-software reset also ends idle.
// R13 - Software sets watchdog run-in-idle if watchdog reset must end idle.
// R14 - Writing 1 to the power-down bit enters power-down after that write.
// R15 - Power-down stops the oscillator, CPU, peripherals and flash.
// R16 - Every non-software reset, brown-out included, ends power-down.
// R17 - After reset wake the CPU restarts from program start.
// R18 - Wake interrupt restarts the oscillator; CPU runs once it is stable.
// R19 - Hardware clears the power-down bit on wake before the service routine.
// R20 - Wake sources: two external irqs, pin, watchdog, wake timer, brown-out.
// R21 - Idle and power-down set together enter power-down, no idle afterwards.
// R22 - Software enables brown-out detection before power-down if it must wake.
`ifndef SCD_REGS_SVH
`define SCD_REGS_SVH

`define SCD_ADDR_PWR_CTRL 8'h87
`define SCD_ADDR_CLK_MISC 8'h8E
`define SCD_ADDR_DIV 8'h95

`define SCD_RST_PWR_CTRL 8'h10
`define SCD_RST_CLK_MISC 8'h00
`define SCD_RST_DIV 8'h00

`define SCD_PWR_IDLE_BIT 0
`define SCD_PWR_PDOWN_BIT 1
`define SCD_PWR_RSVD_BIT 5
`define SCD_MISC_CLKOUT_BIT 1
`define SCD_MISC_WMASK 8'h5A
`define SCD_READ_ZERO 8'h00

`define SCD_NUM_WAKE 6

`endif

// >>> core/scd_pkg.sv
// Purpose: Types shared by the clock divider and power mode controller.
// Assumes: Nothing beyond the register header.
// Notes:   Wake source order matches the wake request input vector.
package scd_pkg;

    typedef enum logic [1:0] {
        SCD_ST_RUN,
        SCD_ST_IDLE,
        SCD_ST_PDOWN,
        SCD_ST_WAKE
    } scd_state_t;

    typedef enum logic [2:0] {
        SCD_WK_EXT0,
        SCD_WK_EXT1,
        SCD_WK_PIN,
        SCD_WK_WDT,
        SCD_WK_WKT,
        SCD_WK_BOD
    } scd_wake_src_t;

endpackage

// >>> core/scd_div_if.sv
// Purpose: Carries divider setting and generated clock state between the
//          controller and the clock generator.
// Assumes: Both ends on sys_clk.
// Notes:   None.
`timescale 1ns/100ps
interface scd_div_if #(parameter int DIV_W = 8);
    logic [DIV_W-1:0] div_value;
    logic run;
    logic tick;
    logic phase;
    logic bypass;

    modport ctrl (output div_value, output run,
                  input tick, input phase, input bypass);
    modport gen (input div_value, input run,
                 output tick, output phase, output bypass);
endinterface

// >>> core/scd_clkgen.sv
// Purpose: Divides the oscillator clock into the system clock waveform and
//          a one-cycle tick marking each system clock rising edge.
// Assumes: run is low only while the system clock must stand still.
// Notes:   A new ratio is picked up only where a period ends.
`timescale 1ns/100ps
module scd_clkgen
    import scd_pkg::*;
#(
    parameter int DIV_W = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    scd_div_if.gen dv
);

    initial begin
        if (DIV_W < 1 || DIV_W > 16) begin
            $error("scd_clkgen: DIV_W out of range");
        end
    end

    logic [DIV_W-1:0] cur_div;
    logic [DIV_W-1:0] cnt;
    logic phase;

    wire bypass = (cur_div == '0);
    wire [DIV_W-1:0] last = DIV_W'(cur_div - 1'b1);
    wire half_end = (cnt == last);
    wire rise = !bypass && half_end && !phase;
    wire leave_bypass = bypass && (dv.div_value != '0);

    // Output high for N cycles, then low for N cycles. R2
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_div <= '0;
            cnt <= '0;
            phase <= 1'b0;
        end else if (!dv.run) begin
            cur_div <= dv.div_value;
            cnt <= '0;
            phase <= 1'b0;
        end else if (bypass) begin
            // Leaving bypass starts with a high half so no high is cut. R4
            cur_div <= dv.div_value;
            cnt <= '0;
            phase <= leave_bypass;
        end else if (half_end) begin
            cnt <= '0;
            phase <= !phase;
            // The tick edge ends a period, so no period mixes two ratios.
            if (rise) begin
                cur_div <= dv.div_value; // R4 R3
            end
        end else begin
            cnt <= DIV_W'(cnt + 1'b1);
        end
    end

    // Every oscillator cycle is a system cycle in bypass. R1
    assign dv.tick = dv.run && (bypass || rise);
    assign dv.phase = phase;
    assign dv.bypass = bypass;
endmodule

// >>> core/scd_pwr_clk.sv
// Purpose: System clock divider, clock output pin and idle / power-down
//          control with wake handling and the three control registers.
// Assumes: sys_clk is the oscillator clock; the oscillator block stops the
//          source on osc_stop while this logic keeps its state.
// Notes:   CPU and peripheral clocks are one-cycle enables on sys_clk.
`timescale 1ns/100ps
`include "scd_regs.svh"
module scd_pwr_clk
    import scd_pkg::*;
#(
    parameter int DIV_W = 8,
    parameter int NUM_WAKE = `SCD_NUM_WAKE
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic irq_pending,
    input wire logic [NUM_WAKE-1:0] wake_req,
    input wire logic hw_rst_req,
    input wire logic osc_ready,
    output logic sys_tick,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic osc_stop,
    output logic flash_stop,
    output logic core_restart,
    output logic clkout_pin,
    output logic clkout_oe,
    output logic [1:0] power_state
);

    initial begin
        if (DIV_W != 8) begin
            $error("scd_pwr_clk: divider register is eight bits wide");
        end
        if (NUM_WAKE < 1) begin
            $error("scd_pwr_clk: at least one wake source needed");
        end
    end

    localparam int SYNC_W = NUM_WAKE + 2;

    // Asynchronous inputs through two flip-flops each.
    logic [SYNC_W-1:0] sync_a;
    logic [SYNC_W-1:0] sync_b;
    wire [SYNC_W-1:0] async_in = {osc_ready, hw_rst_req, wake_req};

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    sync_a[gi] <= 1'b0;
                    sync_b[gi] <= 1'b0;
                end else begin
                    sync_a[gi] <= async_in[gi];
                    sync_b[gi] <= sync_a[gi];
                end
            end
        end
    endgenerate

    wire [NUM_WAKE-1:0] wake_s = sync_b[NUM_WAKE-1:0];
    wire hw_rst_s = sync_b[NUM_WAKE];
    wire osc_ready_s = sync_b[NUM_WAKE+1];

    // Registers.
    logic [7:0] pwr_ctrl;
    logic [7:0] clk_misc;
    logic [7:0] sysclk_div_value;
    scd_state_t state;
    scd_state_t next_state;
    logic wake_by_reset;
    logic next_wake_by_reset;

    wire wr_pwr = reg_wr && (reg_addr == `SCD_ADDR_PWR_CTRL);
    wire wr_misc = reg_wr && (reg_addr == `SCD_ADDR_CLK_MISC);
    wire wr_div = reg_wr && (reg_addr == `SCD_ADDR_DIV);

    wire idle_request_bit = pwr_ctrl[`SCD_PWR_IDLE_BIT];
    wire powerdown_request_bit = pwr_ctrl[`SCD_PWR_PDOWN_BIT];
    wire clkout_enable = clk_misc[`SCD_MISC_CLKOUT_BIT];

    wire wake_any = |wake_s; // R20 R16

    // Wake finished: hardware clears both request bits. R19 R21 R11
    wire wake_done = (state == SCD_ST_WAKE) && osc_ready_s;
    wire idle_exit = (state == SCD_ST_IDLE) && (irq_pending || hw_rst_s);
    wire hw_clear = wake_done || idle_exit;

    // Software write data with the reserved bit forced to zero.
    wire [7:0] pwr_wdata = reg_wdata & ~(8'h01 << `SCD_PWR_RSVD_BIT);
    wire [7:0] pwr_mask = (8'h01 << `SCD_PWR_IDLE_BIT)
                        | (8'h01 << `SCD_PWR_PDOWN_BIT);
    wire [7:0] pwr_cleared = hw_clear ? (pwr_ctrl & ~pwr_mask) : pwr_ctrl;
    // A software write in the clearing cycle wins over the clear.
    wire [7:0] next_pwr = wr_pwr ? pwr_wdata : pwr_cleared;
    wire [7:0] next_misc = wr_misc ? (reg_wdata & `SCD_MISC_WMASK)
                                   : clk_misc;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_ctrl <= `SCD_RST_PWR_CTRL;
            clk_misc <= `SCD_RST_CLK_MISC;
            sysclk_div_value <= `SCD_RST_DIV;
        end else begin
            pwr_ctrl <= next_pwr;
            clk_misc <= next_misc;
            if (wr_div) begin
                sysclk_div_value <= reg_wdata; // R3
            end
        end
    end

    // Read data stand in the cycle after the read strobe.
    wire [7:0] rd_mux =
        (reg_addr == `SCD_ADDR_PWR_CTRL) ? pwr_ctrl :
        (reg_addr == `SCD_ADDR_CLK_MISC) ? clk_misc :
        (reg_addr == `SCD_ADDR_DIV) ? sysclk_div_value : `SCD_READ_ZERO;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= `SCD_READ_ZERO;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end else begin
            reg_rdata <= `SCD_READ_ZERO;
        end
    end

    // Power mode sequencing.
    always_comb begin
        next_state = state;
        next_wake_by_reset = wake_by_reset;
        case (state)
            SCD_ST_RUN: begin
                // Power-down takes priority over idle. R21 R14 R9
                if (powerdown_request_bit) begin
                    next_state = SCD_ST_PDOWN;
                end else if (idle_request_bit) begin
                    next_state = SCD_ST_IDLE;
                end
            end
            SCD_ST_IDLE: begin
                if (idle_exit) begin
                    next_state = SCD_ST_RUN; // R11 R12
                end
            end
            SCD_ST_PDOWN: begin
                if (hw_rst_s) begin
                    next_state = SCD_ST_WAKE; // R16
                    next_wake_by_reset = 1'b1;
                end else if (wake_any) begin
                    next_state = SCD_ST_WAKE; // R18
                    next_wake_by_reset = 1'b0;
                end
            end
            SCD_ST_WAKE: begin
                if (osc_ready_s) begin
                    next_state = SCD_ST_RUN; // R18
                end
            end
            default: begin
                next_state = SCD_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= SCD_ST_RUN;
            wake_by_reset <= 1'b0;
        end else begin
            state <= next_state;
            wake_by_reset <= next_wake_by_reset;
        end
    end

    // Restart the CPU from program start after a reset wake. R17
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            core_restart <= 1'b0;
        end else begin
            core_restart <= wake_done && wake_by_reset;
        end
    end

    // Clock generator.
    scd_div_if #(.DIV_W(DIV_W)) dvi ();

    wire in_pdown = (state == SCD_ST_PDOWN) || (state == SCD_ST_WAKE);
    wire sys_run = !in_pdown && !powerdown_request_bit;

    assign dvi.div_value = sysclk_div_value;
    assign dvi.run = sys_run; // R15

    scd_clkgen #(.DIV_W(DIV_W)) u_clkgen (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .dv(dvi)
    );

    // The CPU stops on the cycle after the entering write. R10 R9 R14
    wire cpu_go = (state == SCD_ST_RUN) && !idle_request_bit
                  && !powerdown_request_bit;

    assign sys_tick = dvi.tick;
    assign cpu_clk_en = dvi.tick && cpu_go; // R10
    assign periph_clk_en = dvi.tick; // R10 R15
    assign osc_stop = (state == SCD_ST_PDOWN); // R15
    assign flash_stop = in_pdown; // R15
    assign power_state = state;

    // Clock output gate, dropped in power-down. R6 R7
    logic clkout_gate;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            clkout_gate <= 1'b0;
        end else begin
            clkout_gate <= clkout_enable && sys_run;
        end
    end

    // Bypass forwards the oscillator itself, else the divided phase. R5 R1
    wire clk_wave = dvi.bypass ? sys_clk : dvi.phase;
    assign clkout_pin = clkout_gate && clk_wave;
    assign clkout_oe = clkout_gate;
endmodule

// >>> sim/scd_pwr_clk_checker.sv
// Purpose: Port assertions for the clock divider and power mode block.
// Assumes: One sys_clk domain, rst_n asynchronous and active low.
// Notes: Bound from the testbench top file.
`timescale 1ns/100ps
module scd_pwr_clk_checker #(
    parameter int DIV_W = 8,
    parameter int NUM_WAKE = 6
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic irq_pending,
    input wire logic [NUM_WAKE-1:0] wake_req,
    input wire logic sys_tick,
    input wire logic cpu_clk_en,
    input wire logic osc_stop,
    input wire logic flash_stop,
    input wire logic core_restart,
    input wire logic clkout_pin,
    input wire logic clkout_oe,
    input wire logic [1:0] power_state
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    wire pc_wr = reg_wr && reg_addr == 8'h87;

    chk_pd_stops: assert property (power_state == 2'd2 |->
        osc_stop && flash_stop && !sys_tick && !clkout_oe)
        else $error("pd stops");
    chk_cpu_held: assert property (power_state inside {2'd1, 2'd2}
        |-> !cpu_clk_en) else $error("cpu clock runs");
    chk_clkout_off: assert property (!clkout_oe |-> !clkout_pin)
        else $error("clkout driven while off");
    chk_idle_exit: assert property (power_state == 2'd1 && irq_pending
        |-> ##[1:2] power_state == 2'd0) else $error("idle not left");
    chk_pd_wake: assert property (power_state == 2'd2 && |wake_req
        |-> ##[1:4] power_state != 2'd2) else $error("no wake");
    chk_rdata_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("rdata not zero");
    chk_idle_entry: assert property (pc_wr && reg_wdata[1:0] == 2'b01
        |=> !cpu_clk_en ##1 power_state == 2'd1) else $error("idle entry");
    chk_pd_entry: assert property (pc_wr && reg_wdata[1]
        |=> !cpu_clk_en ##1 power_state == 2'd2) else $error("pd entry");
    chk_restart_run: assert property (core_restart |->
        power_state == 2'd0) else $error("restart outside run");

    cover property (power_state == 2'd1 ##1 power_state == 2'd0);
    cover property (power_state == 2'd3);
    cover property (core_restart);
    cover property (clkout_oe && clkout_pin);
endmodule

// >>> sim/scd_osc_model.sv
// Purpose: Oscillator start-up model answering the stop request.
// Assumes: Driven on sys_clk, which the bench keeps running.
// Notes: slow selects a long start-up time.
`timescale 1ns/100ps
module scd_osc_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic osc_stop,
    input wire logic slow,
    output logic osc_ready
);
    logic [4:0] cnt;
    // Ready drops at once on stop and comes back only after start-up.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 5'h00;
            osc_ready <= 1'b1;
        end else if (osc_stop) begin
            cnt <= slow ? 5'h1F : 5'h02;
            osc_ready <= 1'b0;
        end else if (cnt != 5'h00) begin
            cnt <= cnt - 5'h01;
        end else begin
            osc_ready <= 1'b1;
        end
    end
endmodule

// >>> sim/sysclk_divider_and_power_modes_tb_top.sv
// Purpose: Self-checking bench for the clock divider and power modes.
// Assumes: 250 MHz sys_clk kept running throughout.
// Notes: Fixed divider values plus one random one, each wake source in turn, random unmapped addresses.
`timescale 1ns/100ps
module sysclk_divider_and_power_modes_tb_top;
    logic sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
    logic irq_pending = 1'b0, hw_rst_req = 1'b0, slow = 1'b0, osc_ready;
    logic [5:0] wake_req = 6'h00;
    logic sys_tick, cpu_clk_en, periph_clk_en, osc_stop, flash_stop;
    logic core_restart, clkout_pin, clkout_oe;
    logic [1:0] power_state;
    int fail_count = 0, checks = 0, seed = 32'h79FE941F, per, hi;
    logic [7:0] divs [5];

    always #2 sys_clk = ~sys_clk;
    scd_pwr_clk dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq_pending(irq_pending), .wake_req(wake_req),
        .hw_rst_req(hw_rst_req), .osc_ready(osc_ready),
        .sys_tick(sys_tick), .cpu_clk_en(cpu_clk_en),
        .periph_clk_en(periph_clk_en), .osc_stop(osc_stop),
        .flash_stop(flash_stop), .core_restart(core_restart),
        .clkout_pin(clkout_pin), .clkout_oe(clkout_oe),
        .power_state(power_state));
    scd_osc_model osc (.sys_clk(sys_clk), .rst_n(rst_n),
        .osc_stop(osc_stop), .slow(slow), .osc_ready(osc_ready));

    function automatic int exp_period(input logic [7:0] n);
        return (n == 8'h00) ? 1 : 2 * n;
    endfunction
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        d = reg_rdata;
        @(posedge sys_clk);
    endtask
    task automatic wait_state(input logic [1:0] s);
        int n;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (power_state !== s && n < 200);
        check("power_state", {6'h00, power_state}, {6'h00, s});
        @(posedge sys_clk);
    endtask
    task automatic wait_tick;
        int n;
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (sys_tick !== 1'b1 && n < 600);
    endtask
    task automatic end_sim;
        if (fail_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        #200000;
        fail_count++;
        end_sim();
    end

    initial begin
        divs = '{8'h00, 8'h01, 8'hFF, 8'h00, 8'h00};
        divs[3] = 8'h02 + 8'($random(seed) & 8'h3F);
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        rd(8'h87);
        check("power_control", d, 8'h10);
        rd(8'h8E);
        check("clock_control_misc", d, 8'h00);
        rd(8'h95);
        check("sysclk_divider", d, 8'h00);
        wr({1'b0, 7'($random(seed))}, 8'hFF);
        rd({1'b0, 7'($random(seed))});
        check("unmapped", d, 8'h00);
        wr(8'h8E, 8'hFF);
        rd(8'h8E);
        check("clock_control_misc", d, 8'h5A);
        foreach (divs[i]) begin
            wr(8'h95, divs[i]);
            repeat (2) wait_tick();
            per = 0;
            hi = 0;
            do begin
                @(negedge sys_clk);
                #1;
                per++;
                hi += clkout_pin;
            end while (sys_tick !== 1'b1 && per < 600);
            check("tick_period", 16'(per), 16'(exp_period(divs[i])));
            check("clkout_high", 16'(hi), {8'h00, divs[i]});
            @(posedge sys_clk);
        end
        wr(8'h8E, 8'h00);
        repeat (2) @(posedge sys_clk);
        check("clkout_oe", {7'h00, clkout_oe}, 8'h00);
        for (int k = 0; k < 2; k++) begin
            wr(8'h87, 8'h01);
            wait_state(2'd1);
            check("periph_in_idle", {7'h00, periph_clk_en}, 8'h01);
            irq_pending <= (k == 0);
            hw_rst_req <= (k == 1);
            wait_state(2'd0);
            irq_pending <= 1'b0;
            hw_rst_req <= 1'b0;
            if (k == 1) begin
                wr(8'h8E, 8'h02);
            end
            rd(8'h87);
            check("idle_bit", d & 8'h03, 8'h00);
        end
        for (int k = 0; k < 6; k++) begin
            slow <= 1'($random(seed));
            wr(8'h87, (k == 0) ? 8'h03 : 8'h02);
            wait_state(2'd2);
            check("osc_stop", {7'h00, osc_stop}, 8'h01);
            check("periph_in_pd", {7'h00, periph_clk_en}, 8'h00);
            check("flash_stop", {7'h00, flash_stop}, 8'h01);
            check("clkout_in_pd", {6'h00, clkout_oe, clkout_pin}, 8'h00);
            wake_req <= 6'h01 << k;
            wait_state(2'd0);
            wake_req <= 6'h00;
            rd(8'h87);
            check("pd_bits", d & 8'h03, 8'h00);
            check("after_wake", {6'h00, power_state}, 8'h00);
            check("clkout_back", {7'h00, clkout_oe}, 8'h01);
        end
        wr(8'h87, 8'h02);
        wait_state(2'd2);
        hw_rst_req <= 1'b1;
        per = 0;
        do begin
            @(negedge sys_clk);
            per++;
        end while (core_restart !== 1'b1 && per < 200);
        check("core_restart", {7'h00, core_restart}, 8'h01);
        end_sim();
    end
endmodule

bind scd_pwr_clk scd_pwr_clk_checker #(.DIV_W(DIV_W), .NUM_WAKE(NUM_WAKE))
    u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq_pending(irq_pending),
    .wake_req(wake_req), .sys_tick(sys_tick), .cpu_clk_en(cpu_clk_en),
    .osc_stop(osc_stop), .flash_stop(flash_stop),
    .core_restart(core_restart), .clkout_pin(clkout_pin),
    .clkout_oe(clkout_oe), .power_state(power_state));
